// *** hdl/fpp_params.svh ***
// Constants of the flash read-configuration and page-program block
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH

// Instruction codes
`define FPP_OP_SET_WRAP     8'h77
`define FPP_OP_SET_PARAM    8'hC0
`define FPP_OP_PAGE_PROG    8'h02
`define FPP_OP_PAGE_PROG4   8'h12
`define FPP_OP_QUAD_PROG    8'h32

// Bit counts of frame fields
`define FPP_ADDR_BITS_3B    6'h18
`define FPP_ADDR_BITS_4B    6'h20
`define FPP_BYTE_LAST       4'h7
`define FPP_BYTE_BITS       4'h8
`define FPP_QUAD_STEP       4'h4
`define FPP_SINGLE_STEP     4'h1

// Reset values of the setting registers
`define FPP_WRAP_RESET      8'h10
`define FPP_PARAM_RESET     8'h00

// Field positions
`define FPP_WRAP_DIS_POS    4
`define FPP_WRAP_LEN_LSB    5
`define FPP_PARAM_DUMMY_LSB 4

// Dummy clock encoding
`define FPP_DUMMY_MIN       5'h06
`define FPP_DUMMY_MIN_CODE  3'h3

`endif

// *** hdl/fpp_pkg.sv ***
// Types shared by the flash read-configuration and page-program block
package fpp_pkg;

    // Frame decoder states, one-hot
    typedef enum logic [6:0] {
        FPP_CMD   = 7'h01,
        FPP_DUMMY = 7'h02,
        FPP_WRAPB = 7'h04,
        FPP_PARAM = 7'h08,
        FPP_ADDR  = 7'h10,
        FPP_DATA  = 7'h20,
        FPP_SKIP  = 7'h40
    } fpp_frame_t;

    // One byte to be written to the array
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  data;
    } fpp_word_t;

    // Read settings handed to the quad read datapath
    typedef struct packed {
        logic       wrap_en;
        logic [1:0] wrap_len;
        logic [4:0] dummy_clks;
    } fpp_read_cfg_t;

    // Whole state of the main module
    typedef struct packed {
        logic             cs_s1;
        logic             cs_s2;
        logic             cs_d;
        logic             sck_s1;
        logic             sck_s2;
        logic             sck_d;
        logic [3:0]       io_s1;
        logic [3:0]       io_s2;
        fpp_frame_t       fst;
        logic [3:0]       bcnt;
        logic [5:0]       left;
        logic [7:0]       sh;
        logic             quad;
        logic             got_byte;
        logic [31:0]      addr;
        logic [7:0]       ptr;
        logic [255:0][7:0] page;
        logic [255:0]     mask;
        logic             busy;
        logic             scan;
        logic [7:0]       idx;
        logic             wel_clr;
        logic [7:0]       wrap_setting;
        logic [7:0]       read_params;
        logic [31:0]      rd_addr;
    } fpp_state_t;

endpackage

// *** hdl/fpp_two_buf.sv ***
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module fpp_two_buf #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } fpp_buf_state_t;

    fpp_buf_state_t s_reg;
    fpp_buf_state_t s_next;
    logic           push;
    logic           pop;

    // Honest full and empty from the fill count
    assign in_ready  = (s_reg.cnt != (PW+1)'(DEPTH));
    assign out_valid = (s_reg.cnt != '0);
    assign out_data  = s_reg.mem[s_reg.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data;
            s_next.wp = (s_reg.wp == PW'(DEPTH - 1)) ? '0 : s_reg.wp + PW'(1);
        end
        if (pop) begin
            s_next.rp = (s_reg.rp == PW'(DEPTH - 1)) ? '0 : s_reg.rp + PW'(1);
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + (PW+1)'(1);
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - (PW+1)'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// *** hdl/fpp_core.sv ***
// Serial flash wrap, read-parameter and page-program command handling
//
// Overview of operation
// - Wrap setup frame: opcode 77h, 24 dummy bits, then eight wrap bits.
// - In four-byte address mode the wrap frame carries 32 dummy bits.
// - Disable bit zero enables wrap; length code picks 8/16/32/64 bytes.
// - Stored wrap setting applies to all later quad reads until rewritten.
// - Any reset sets the wrap disable bit, turning wrapping off.
// - In single-line mode C0h updates only the three dummy bits.
// - Stored dummy setting sets dummy cycles of quad reads in both forms.
// - Codes 0..2 give 6 cycles; 3..7 give 8,10,12,14,16.
// - Mode switching between SPI and four-wire leaves both settings unchanged.
// - Any reset clears all eight read parameter bits.
// - Page program is refused unless the write enable latch is set.
// - One program takes between one and 256 data bytes.
// - Program address wraps inside the page; extra bytes overwrite earlier ones.
// - Program runs only if select rises exactly on a byte boundary.
// - After select rises a self-timed cycle runs with busy set.
// - Program completion clears the write enable latch.
// - Protected or locked pages are never programmed.
// - Opcode 12h always takes a 32-bit address.
// - Opcode 32h takes data on four lines and needs the quad enable bit.
// - Wrapped quad reads return to the section start at its end boundary.
`timescale 1ns/1ps
`default_nettype none

`include "fpp_params.svh"

module fpp_core
    import fpp_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RST_N,
    // Serial link pins, asynchronous to CLK
    input  wire logic          CS_N,
    input  wire logic          SCK,
    input  wire logic [3:0]    IO_IN,
    // Device state from surrounding logic on CLK
    input  wire logic          WRITE_ENABLE_LATCH,
    input  wire logic          QUAD_ENABLE_BIT,
    input  wire logic          ADDR_4BYTE_MODE,
    input  wire logic          FOUR_WIRE_INSTRUCTION_MODE,
    input  wire logic          SOFT_RESET,
    // Protection check of the addressed page
    output logic [31:0]        PROG_PAGE_ADDR,
    input  wire logic          PAGE_LOCKED,
    // Program status
    output logic               BUSY,
    output logic               WEL_CLEAR,
    // Array write port
    output logic               PROG_VALID,
    input  wire logic          PROG_READY,
    output fpp_word_t          PROG_WORD,
    // Quad read settings and address sequencer
    output fpp_read_cfg_t      READ_CFG,
    input  wire logic          RD_LOAD,
    input  wire logic [31:0]   RD_LOAD_ADDR,
    input  wire logic          RD_STEP,
    output logic [31:0]        RD_ADDR
);

    fpp_state_t s_reg;
    fpp_state_t s_next;

    logic       sck_rise;
    logic       cs_rise;
    logic       cs_low;
    logic       di;
    logic [7:0] byte_in;
    logic [7:0] quad_in;
    logic [3:0] step;
    logic       byte_done;
    logic [7:0] data_byte;
    logic       buf_in_valid;
    logic       buf_in_ready;
    fpp_word_t  buf_in_word;
    logic       buf_out_valid;
    logic [7:0] wrap_mask;
    logic [31:0] rd_inc;

    // Returns the dummy clock count for a three-bit code
    function automatic logic [4:0] dummy_of(input logic [2:0] code);
        logic [4:0] r;
        r = `FPP_DUMMY_MIN;
        if (code >= `FPP_DUMMY_MIN_CODE) begin
            r = {1'b0, code, 1'b0} + 5'h02;
        end
        return r;
    endfunction

    // Edges from second-stage flops and their delay flops, sampled lines from second-stage flops
    assign sck_rise = s_reg.sck_s2 & ~s_reg.sck_d;
    assign cs_rise  = s_reg.cs_s2 & ~s_reg.cs_d;
    assign cs_low   = ~s_reg.cs_s2;
    assign di       = s_reg.io_s2[0];
    assign byte_in  = {s_reg.sh[6:0], di};
    assign quad_in  = {s_reg.sh[3:0], s_reg.io_s2};

    // Data bits per clock during the program data phase
    assign step      = s_reg.quad ? `FPP_QUAD_STEP : `FPP_SINGLE_STEP;
    assign byte_done = ((s_reg.bcnt + step) == `FPP_BYTE_BITS);
    assign data_byte = s_reg.quad ? quad_in : byte_in;

    // Write-out of collected page bytes into the buffer
    assign buf_in_valid       = s_reg.busy & s_reg.scan & s_reg.mask[s_reg.idx];
    assign buf_in_word.addr   = {s_reg.addr[31:8], s_reg.idx};
    assign buf_in_word.data   = s_reg.page[s_reg.idx];

    // Section mask of the wrapped read
    assign wrap_mask = 8'(({3'h0, 5'h08} << s_reg.wrap_setting[`FPP_WRAP_LEN_LSB +: 2]) - 8'h01);
    assign rd_inc    = s_reg.rd_addr + 32'h0000_0001;

    always_comb begin
        s_next = s_reg;
        s_next.wel_clr = 1'b0;

        // Two-flop synchronisers plus one delay for edge finding
        s_next.cs_s1  = CS_N;
        s_next.cs_s2  = s_reg.cs_s1;
        s_next.cs_d   = s_reg.cs_s2;
        s_next.sck_s1 = SCK;
        s_next.sck_s2 = s_reg.sck_s1;
        s_next.sck_d  = s_reg.sck_s2;
        s_next.io_s1  = IO_IN;
        s_next.io_s2  = s_reg.io_s1;

        if (cs_rise) begin
            if ((s_reg.fst == FPP_DATA) && (s_reg.bcnt == 4'h0) && s_reg.got_byte && !s_reg.busy) begin
                if (!PAGE_LOCKED) begin
                    s_next.busy = 1'b1;
                    s_next.scan = 1'b1;
                    s_next.idx  = 8'h00;
                end
            end
            s_next.fst  = FPP_CMD;
            s_next.bcnt = 4'h0;
        end else if (cs_low && sck_rise) begin
            case (s_reg.fst)
                FPP_CMD: begin
                    s_next.sh   = byte_in;
                    s_next.bcnt = s_reg.bcnt + 4'h1;
                    if (s_reg.bcnt == `FPP_BYTE_LAST) begin
                        s_next.bcnt     = 4'h0;
                        s_next.quad     = 1'b0;
                        s_next.got_byte = 1'b0;
                        s_next.addr     = 32'h0000_0000;
                        s_next.fst      = FPP_SKIP;
                        case (byte_in)
                            `FPP_OP_SET_WRAP: begin
                                s_next.left = ADDR_4BYTE_MODE ? `FPP_ADDR_BITS_4B : `FPP_ADDR_BITS_3B;
                                s_next.fst  = FPP_DUMMY;
                            end
                            `FPP_OP_SET_PARAM: begin
                                s_next.fst = FOUR_WIRE_INSTRUCTION_MODE ? FPP_SKIP : FPP_PARAM;
                            end
                            `FPP_OP_PAGE_PROG, `FPP_OP_PAGE_PROG4, `FPP_OP_QUAD_PROG: begin
                                s_next.left = (ADDR_4BYTE_MODE || (byte_in == `FPP_OP_PAGE_PROG4)) ?
                                              `FPP_ADDR_BITS_4B : `FPP_ADDR_BITS_3B;
                                s_next.quad = (byte_in == `FPP_OP_QUAD_PROG);
                                if (WRITE_ENABLE_LATCH && !s_reg.busy &&
                                    ((byte_in != `FPP_OP_QUAD_PROG) || QUAD_ENABLE_BIT)) begin
                                    s_next.fst = FPP_ADDR;
                                end
                            end
                            default: begin
                                s_next.fst = FPP_SKIP;
                            end
                        endcase
                    end
                end
                FPP_DUMMY: begin
                    // Dummy bits carry nothing
                    s_next.left = s_reg.left - 6'h01;
                    if (s_reg.left == 6'h01) begin
                        s_next.fst  = FPP_WRAPB;
                        s_next.bcnt = 4'h0;
                    end
                end
                FPP_WRAPB: begin
                    s_next.sh   = byte_in;
                    s_next.bcnt = s_reg.bcnt + 4'h1;
                    if (s_reg.bcnt == `FPP_BYTE_LAST) begin
                        s_next.wrap_setting = 8'h00;
                        s_next.wrap_setting[`FPP_WRAP_DIS_POS] = byte_in[`FPP_WRAP_DIS_POS];
                        s_next.wrap_setting[`FPP_WRAP_LEN_LSB +: 2] = byte_in[`FPP_WRAP_LEN_LSB +: 2];
                        s_next.bcnt = 4'h0;
                        s_next.fst  = FPP_SKIP;
                    end
                end
                FPP_PARAM: begin
                    s_next.sh   = byte_in;
                    s_next.bcnt = s_reg.bcnt + 4'h1;
                    if (s_reg.bcnt == `FPP_BYTE_LAST) begin
                        s_next.read_params[`FPP_PARAM_DUMMY_LSB +: 3] = byte_in[`FPP_PARAM_DUMMY_LSB +: 3];
                        s_next.bcnt = 4'h0;
                        s_next.fst  = FPP_SKIP;
                    end
                end
                FPP_ADDR: begin
                    s_next.addr = {s_reg.addr[30:0], di};
                    s_next.left = s_reg.left - 6'h01;
                    if (s_reg.left == 6'h01) begin
                        s_next.fst  = FPP_DATA;
                        s_next.bcnt = 4'h0;
                        s_next.ptr  = {s_reg.addr[6:0], di};
                        s_next.mask = '0;
                    end
                end
                FPP_DATA: begin
                    s_next.sh   = data_byte;
                    s_next.bcnt = s_reg.bcnt + step;
                    if (byte_done) begin
                        s_next.page[s_reg.ptr] = data_byte;
                        s_next.mask[s_reg.ptr] = 1'b1;
                        s_next.ptr      = s_reg.ptr + 8'h01;
                        s_next.got_byte = 1'b1;
                        s_next.bcnt     = 4'h0;
                    end
                end
                FPP_SKIP: begin
                    s_next.fst = FPP_SKIP;
                end
                default: begin
                    s_next.fst = FPP_SKIP;
                end
            endcase
        end

        // Self-timed write-out, stalled by the array port
        if (s_reg.busy) begin
            if (s_reg.scan) begin
                if (!s_reg.mask[s_reg.idx] || buf_in_ready) begin
                    s_next.idx = s_reg.idx + 8'h01;
                    if (s_reg.idx == 8'hFF) begin
                        s_next.scan = 1'b0;
                    end
                end
            end else if (!buf_out_valid) begin
                s_next.busy = 1'b0;
                s_next.wel_clr = 1'b1;
            end
        end

        // read address steps inside the section while wrap is enabled, else linearly
        if (RD_LOAD) begin
            s_next.rd_addr = RD_LOAD_ADDR;
        end else if (RD_STEP) begin
            if (!s_reg.wrap_setting[`FPP_WRAP_DIS_POS]) begin
                s_next.rd_addr = (s_reg.rd_addr & ~{24'h000000, wrap_mask}) |
                                 (rd_inc & {24'h000000, wrap_mask});
            end else begin
                s_next.rd_addr = rd_inc;
            end
        end

        if (SOFT_RESET) begin
            s_next.wrap_setting = `FPP_WRAP_RESET;
            s_next.read_params  = `FPP_PARAM_RESET;
        end
    end

    // State register; settings ignore instruction mode changes
    // mode leaves settings
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_reg              <= '0;
            s_reg.cs_s1        <= 1'b1;
            s_reg.cs_s2        <= 1'b1;
            s_reg.cs_d         <= 1'b1;
            s_reg.fst          <= FPP_CMD;
            s_reg.wrap_setting <= `FPP_WRAP_RESET;
            s_reg.read_params  <= `FPP_PARAM_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Buffer toward the array write port
    fpp_two_buf #(
        .WIDTH ($bits(fpp_word_t)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_word),
        .out_valid (buf_out_valid),
        .out_ready (PROG_READY),
        .out_data  (PROG_WORD)
    );

    // Outputs
    assign PROG_VALID          = buf_out_valid;
    assign PROG_PAGE_ADDR      = s_reg.addr;
    assign BUSY                = s_reg.busy;
    assign WEL_CLEAR           = s_reg.wel_clr;
    assign RD_ADDR             = s_reg.rd_addr;
    assign READ_CFG.wrap_en    = ~s_reg.wrap_setting[`FPP_WRAP_DIS_POS];
    assign READ_CFG.wrap_len   = s_reg.wrap_setting[`FPP_WRAP_LEN_LSB +: 2];
    assign READ_CFG.dummy_clks = dummy_of(s_reg.read_params[`FPP_PARAM_DUMMY_LSB +: 3]);

endmodule

`default_nettype wire

// *** bench/fpp_host_model.sv ***
// Host SPI controller model driving the serial link pins
`timescale 1ns/1ps
`default_nettype none

module fpp_host_model (
    // Link pins
    output logic       cs_n,
    output logic       sck,
    output logic [3:0] io
);
    // Idle link: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        io   = 4'h5;
    end

    // select held low for the frame
    task automatic sel;
        cs_n = 1'b0;
        #62.5;
    endtask

    // bits MSB first, one line or four
    task automatic shift(input logic [63:0] v, input int n, input bit q);
        for (int i = n; i > 0; i -= (q ? 4 : 1)) begin
            io = q ? v[i-1 -: 4] : {~io[3:1], v[i-1]};
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
    endtask

    // Release select; released lines no longer hold their last value
    task automatic desel;
        #62.5 cs_n = 1'b1;
        io = ~io;
        #100;
    endtask
endmodule
`default_nettype wire

// *** bench/fpp_core_monitor.sv ***
// Port checks of the flash configuration and program block
`timescale 1ns/1ps
`default_nettype none

module fpp_core_monitor
    import fpp_pkg::*;
(
    // Clock and reset
    input wire logic          CLK,
    input wire logic          RST_N,
    // Control inputs
    input wire logic          CS_N,
    input wire logic          SOFT_RESET,
    input wire logic          PROG_READY,
    input wire logic          RD_LOAD,
    input wire logic [31:0]   RD_LOAD_ADDR,
    input wire logic          RD_STEP,
    // Watched outputs
    input wire logic          BUSY,
    input wire logic          WEL_CLEAR,
    input wire logic          PROG_VALID,
    input wire fpp_word_t     PROG_WORD,
    input wire fpp_read_cfg_t READ_CFG,
    input wire logic [31:0]   RD_ADDR
);
    logic [31:0] sec_mask;
    logic [31:0] step_nxt;

    // Next read address: modulo the wrap section, else linear
    always_comb begin
        sec_mask = (32'h8 << READ_CFG.wrap_len) - 32'h1;
        step_nxt = RD_ADDR + 32'h1;
        if (READ_CFG.wrap_en)
            step_nxt = (RD_ADDR & ~sec_mask) | (step_nxt & sec_mask);
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_cfg_reset;
        $rose(RST_N) |-> READ_CFG == 8'h06;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("settings not at reset value");
    property p_soft;
        SOFT_RESET |-> ##[1:4] READ_CFG == 8'h06;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset did not restore settings");
    property p_cfg_hold;
        (CS_N && !SOFT_RESET) [*6] |=> $stable(READ_CFG);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed while idle");
    property p_rd_load;
        RD_LOAD |=> RD_ADDR == $past(RD_LOAD_ADDR);
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read address not loaded");
    property p_rd_step;
        RD_STEP && !RD_LOAD |=> RD_ADDR == $past(step_nxt);
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read address step wrong");
    property p_wel_busy;
        WEL_CLEAR == $fell(BUSY);
    endproperty
    a_wel_busy: assert property (p_wel_busy) else $error("latch clear not at cycle end");
    property p_busy_cs;
        $rose(BUSY) |-> CS_N && $past(CS_N, 2);
    endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("program began while selected");
    property p_valid_busy;
        PROG_VALID |-> BUSY;
    endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("write-out outside busy");
    property p_word_hold;
        PROG_VALID && !PROG_READY |=> PROG_VALID && $stable(PROG_WORD);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("stalled word lost");
endmodule

bind fpp_core fpp_core_monitor u_mon (
    .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SOFT_RESET(SOFT_RESET), .PROG_READY(PROG_READY),
    .RD_LOAD(RD_LOAD), .RD_LOAD_ADDR(RD_LOAD_ADDR), .RD_STEP(RD_STEP), .BUSY(BUSY),
    .WEL_CLEAR(WEL_CLEAR), .PROG_VALID(PROG_VALID), .PROG_WORD(PROG_WORD),
    .READ_CFG(READ_CFG), .RD_ADDR(RD_ADDR)
);
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the flash configuration and program block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fpp_pkg::*;

    logic          clk = 1'b0, rst_n = 1'b0, write_enable_latch = 1'b0, qe = 1'b0, a4 = 1'b0, fw = 1'b0;
    logic          srst = 1'b0, locked = 1'b0, prog_ready = 1'b0, rd_load = 1'b0, rd_step = 1'b0;
    logic [31:0]   rd_load_addr = 32'h0, rd_addr, ppa;
    logic          cs_n, sck, busy, wel_clear, prog_valid;
    logic [3:0]    io;
    fpp_word_t     prog_word;
    fpp_read_cfg_t read_cfg;
    logic [7:0]    d[$], nob[$];
    int            error_cnt = 0, n_compared = 0;

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    fpp_host_model u_host (.cs_n(cs_n), .sck(sck), .io(io));

    fpp_core #(.BUF_DEPTH(2)) u_dut (
        .CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck), .IO_IN(io),
        .WRITE_ENABLE_LATCH(write_enable_latch), .QUAD_ENABLE_BIT(qe), .ADDR_4BYTE_MODE(a4),
        .FOUR_WIRE_INSTRUCTION_MODE(fw), .SOFT_RESET(srst), .PROG_PAGE_ADDR(ppa),
        .PAGE_LOCKED(locked), .BUSY(busy), .WEL_CLEAR(wel_clear), .PROG_VALID(prog_valid),
        .PROG_READY(prog_ready), .PROG_WORD(prog_word), .READ_CFG(read_cfg), .RD_LOAD(rd_load),
        .RD_LOAD_ADDR(rd_load_addr), .RD_STEP(rd_step), .RD_ADDR(rd_addr)
    );

    // Compare one result and count it
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Setting frame: opcode then n body bits
    task automatic frame(input logic [7:0] op, input logic [63:0] body, input int n);
        u_host.sel();
        u_host.shift({56'h0, op}, 8, 1'b0);
        u_host.shift(body, n, 1'b0);
        u_host.desel();
        @(negedge clk);
    endtask

    // Program frame with an optional broken tail of cut bits
    task automatic prog(input logic [7:0] op, input logic [31:0] a, input int ab, input bit q,
                        input logic [7:0] wd[$], input int cut);
        u_host.sel();
        u_host.shift({56'h0, op}, 8, 1'b0);
        u_host.shift({32'h0, a}, ab, 1'b0);
        foreach (wd[j]) u_host.shift({56'h0, wd[j]}, 8, q);
        u_host.shift(64'h0, cut, 1'b0);
        u_host.desel();
    endtask

    // Program cycle: stall the array side, compare the written words
    task automatic drain(input logic [31:0] a, input logic [7:0] wd[$]);
        logic [7:0] mem[256];
        bit         hit[256];
        fpp_word_t  exp[$], got[$];
        int         t, wc;
        t = 0;
        wc = 0;
        foreach (wd[j]) begin
            mem[8'(a[7:0] + j)] = wd[j];
            hit[8'(a[7:0] + j)] = 1'b1;
        end
        for (int k = 0; k < 256; k++)
            if (hit[k]) exp.push_back({a[31:8], k[7:0], mem[k]});
        @(negedge clk);
        chk("busy", wd.size() > 0, busy);
        if (wd.size() > 0) chk("page", a, ppa);
        while (busy === 1'b1 && t < 3000) begin
            @(negedge clk);
            prog_ready = t[2] | t[0];
            if (prog_valid === 1'b1 && prog_ready) got.push_back(prog_word);
            wc += wel_clear;
            t++;
        end
        prog_ready = 1'b0;
        chk("count", exp.size(), got.size());
        foreach (exp[k]) chk("word", exp[k], k < got.size() ? got[k] : 40'h0);
        chk("wel_clear", wd.size() > 0, wc);
    endtask

    // Read sequencer: load, then four single-byte steps
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_load = 1'b1;
        rd_load_addr = a;
        @(negedge clk);
        rd_load = 1'b0;
        rd_step = 1'b1;
        repeat (4) @(negedge clk);
        rd_step = 1'b0;
        chk("rd_addr", e, rd_addr);
    endtask

    // Wrap settings in both address modes, then a wrapped and a linear read
    task automatic t_wrap;
        for (int c = 0; c < 4; c++) begin
            a4 = c[0];
            frame(8'h77, {56'h0, 1'b1, c[1:0], 5'h0F}, a4 ? 40 : 32);
            chk("cfg", {1'b1, c[1:0], 5'h06}, read_cfg);
        end
        fw = 1'b1;
        @(negedge clk);
        fw = 1'b0;
        a4 = 1'b0;
        @(negedge clk);
        chk("cfg", 8'hE6, read_cfg);
        rd(32'h0000_12FC, 32'h0000_12C0);
        frame(8'h77, {56'h0, 8'h10}, 32);
        chk("cfg", 8'h06, read_cfg);
        rd(32'h0000_12FC, 32'h0000_1300);
    endtask

    // Every dummy code, four-wire mode, soft reset
    task automatic t_param;
        for (int c = 0; c < 8; c++) begin
            frame(8'hC0, {56'h0, 1'b1, c[2:0], 4'h3}, 8);
            chk("cfg", {3'h0, (c < 3) ? 5'h06 : 5'(2 * c + 2)}, read_cfg);
        end
        fw = 1'b1;
        frame(8'hC0, 64'h03, 8);
        fw = 1'b0;
        @(negedge clk);
        chk("cfg", 8'h10, read_cfg);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk("cfg", 8'h06, read_cfg);
    endtask

    // Over-long page program, then 4-byte and quad forms
    task automatic t_prog;
        write_enable_latch = 1'b1;
        for (int j = 0; j < 258; j++) d.push_back(8'(j) ^ 8'h3C);
        prog(8'h02, 32'h0000_12FE, 24, 1'b0, d, 0);
        drain(32'h0000_12FE, d);
        d = '{8'h96};
        prog(8'h12, 32'h0102_0304, 32, 1'b0, d, 0);
        drain(32'h0102_0304, d);
        qe = 1'b1;
        d = '{8'h5A, 8'hC3};
        prog(8'h32, 32'h0000_0410, 24, 1'b1, d, 0);
        drain(32'h0000_0410, d);
    endtask

    // Frames that must not start a program cycle
    task automatic t_refuse;
        d = '{8'hA5};
        write_enable_latch = 1'b0;
        prog(8'h02, 32'h100, 24, 1'b0, d, 0);
        drain(32'h100, nob);
        write_enable_latch = 1'b1;
        prog(8'h02, 32'h100, 24, 1'b0, d, 3);
        drain(32'h100, nob);
        prog(8'h02, 32'h100, 24, 1'b0, nob, 0);
        drain(32'h100, nob);
        locked = 1'b1;
        prog(8'h02, 32'h100, 24, 1'b0, d, 0);
        drain(32'h100, nob);
        locked = 1'b0;
        qe = 1'b0;
        prog(8'h32, 32'h100, 24, 1'b1, d, 0);
        drain(32'h100, nob);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("cfg", 8'h06, read_cfg);
        t_wrap();
        t_param();
        t_prog();
        t_refuse();
        stop_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #600000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
